/* File: verilog/pmbus_status_telemetry_bank.sv */
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Unknown or unsupported command latches bit 7
// - Invalid data for command latches bit 6
// - Failed packet error check latches bit 5
// - Internal memory error latches bit 4
// - Logic core error latches bit 3
// - Communication error latches bit 1; 2,0 zero
// - Follower back-channel problem reported as communication fault
// - Summary bit is OR of latched bits
// - Clearing the byte also clears summary bit
// - First-alerter bit set only if asserted first
// - Misc status bits 7 to 1 read zero
// - Power-on check failure latches vendor bit 7
// - Vendor bit 6 live: self-check busy
// - Output restart event latches vendor bit 3
// - Back-channel fault latches vendor bit 2
// - Sync fault latches vendor bit 1
// - Vendor bits 5 and 4 read zero
// - Writing 1 clears a set bit
// - Clear-faults command clears every latched bit
// - Each alerting bit has its own mask bit
// - Input voltage returned as linear-format word
// - Input voltage refreshed once per millisecond
// - Write to read-only reading flags invalid command
// - Phase FFh or an out-of-range phase gives leader, else that phase
module pmbus_status_telemetry_bank
  import status_bank_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES,
  parameter int unsigned PHASES           = PHASE_COUNT
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      srst,

  // Command port from the PMBus protocol engine
  input  wire logic                      cmd_valid,
  input  wire logic                      cmd_write,
  input  wire logic [7:0]                cmd_code,
  input  wire logic [7:0]                cmd_wdata,
  input  wire logic                      cmd_pec_ok,
  output logic                           rsp_valid,
  output logic [15:0]                    rsp_data,

  // Communication, logic and memory events
  input  wire logic                      unsupported_cmd_event,
  input  wire logic                      invalid_data_event,
  input  wire logic                      memory_error_event,
  input  wire logic                      logic_core_error_event,
  input  wire logic                      communication_error_flag_error_event,

  // Stacking and alert arbitration
  input  wire logic                      is_follower,
  input  wire logic                      back_channel_fault,
  input  wire logic                      first_alert_won,
  input  wire logic                      alert_released,

  // Vendor events and live state
  input  wire logic                      power_on_check_fail,
  input  wire logic                      self_check_busy,
  input  wire logic                      output_restart_event,
  input  wire logic                      sync_fault_event,

  // Alert masks, one bit per status bit
  input  wire logic [7:0]                alert_mask_cml,
  input  wire logic [7:0]                alert_mask_vendor,

  // Input-voltage telemetry
  input  wire logic [7:0]                phase_select,
  input  wire logic [15:0]               leader_vin_word,
  input  wire logic [PHASES*16-1:0]      phase_vin_word,

  // Summary bits and alert request
  output logic                           cml_summary,
  output logic                           other_summary,
  output logic                           vendor_summary,
  output logic                           alert_request
);

  typedef struct packed {
    logic [7:0]  cml;
    logic [7:0]  other;
    logic [7:0]  vendor;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        cml_summary;
    logic        other_summary;
    logic        vendor_summary;
    logic        alert_request;
  } bank_state_type;

  bank_state_type q, d;

  logic [7:0] cml_set;
  logic [7:0] cml_clr;
  logic [7:0] other_set;
  logic [7:0] other_clr;
  logic [7:0] vendor_set;
  logic [7:0] vendor_clr;
  logic       accepted;
  logic       bad_pec;
  logic       live_busy;

  vin_link_if vin_link ();

  vin_sampler #(
    .REFRESH_CYCLES_P (REFRESH_CYCLES_P),
    .PHASES           (PHASES)
  ) u_vin_sampler (
    .clock           (clock),
    .srst            (srst),
    .leader_vin_word (leader_vin_word),
    .phase_vin_word  (phase_vin_word),
    .link            (vin_link.source)
  );

  assign vin_link.phase_sel = phase_select;

  // A command whose PEC failed is recorded and otherwise dropped,
  // so a corrupted write can never clear a flag by accident.
  assign bad_pec  = cmd_valid && !cmd_pec_ok;
  assign accepted = cmd_valid && cmd_pec_ok;

  // Event sources
  always_comb begin
    cml_set    = 8'h00;
    other_set  = 8'h00;
    vendor_set = 8'h00;

    cml_set[CML_INVALID_CMD_BIT]  = unsupported_cmd_event;
    cml_set[CML_INVALID_DATA_BIT] = invalid_data_event;
    cml_set[CML_PEC_BIT]          = bad_pec;
    cml_set[CML_MEMORY_BIT]       = memory_error_event;
    cml_set[CML_LOGIC_CORE_BIT]   = logic_core_error_event;
    // A follower owns no separate back-channel flag in this byte, so
    // the problem is folded into its own communication error.
    cml_set[CML_COMMUNICATION_ERROR_FLAG_BIT]         = communication_error_flag_error_event
                                    || (is_follower && back_channel_fault);

    if (accepted && cmd_write && cmd_code == CMD_INPUT_VOLTAGE_READING) begin
      cml_set[CML_INVALID_CMD_BIT] = 1'b1;
    end

    other_set[OTHER_FIRST_ALERT_BIT] = first_alert_won;

    vendor_set[VENDOR_POWER_ON_BIT]  = power_on_check_fail;
    vendor_set[VENDOR_RESTART_BIT]   = output_restart_event;
    vendor_set[VENDOR_BACK_CHAN_BIT] = back_channel_fault;
    vendor_set[VENDOR_SYNC_BIT]      = sync_fault_event;
  end

  // Host clears: write-one-to-clear per byte, or everything at once
  always_comb begin
    cml_clr    = 8'h00;
    other_clr  = 8'h00;
    vendor_clr = 8'h00;

    if (accepted && cmd_write) begin
      case (cmd_code)
        CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS: begin
          cml_clr = cmd_wdata & CML_SUPPORTED;
        end
        CMD_STATUS_OTHER: begin
          other_clr = cmd_wdata & OTHER_SUPPORTED;
        end
        CMD_STATUS_VENDOR: begin
          vendor_clr = cmd_wdata & VENDOR_LATCHED;
        end
        CMD_CLEAR_FAULTS: begin
          cml_clr    = CML_SUPPORTED;
          other_clr  = OTHER_SUPPORTED;
          vendor_clr = VENDOR_LATCHED;
        end
        default: begin
        end
      endcase
    end

    // Once the bus alert is released this device is no longer first
    if (alert_released) begin
      other_clr[OTHER_FIRST_ALERT_BIT] = 1'b1;
    end
  end

  assign live_busy = self_check_busy;

  // Next state
  always_comb begin
    d = q;

    // Set is applied after clear so a coincident event survives
    d.cml    = ((q.cml & ~cml_clr) | cml_set) & CML_SUPPORTED;
    d.other  = ((q.other & ~other_clr) | other_set) & OTHER_SUPPORTED;
    d.vendor = ((q.vendor & ~vendor_clr) | vendor_set) & VENDOR_LATCHED;

    // Live bit is a plain mirror and ignores clears
    d.vendor[VENDOR_SELF_CHECK_BIT] = live_busy;

    // Summaries follow the new byte contents, both ways
    d.cml_summary    = |d.cml;
    d.other_summary  = |d.other;
    d.vendor_summary = |(d.vendor & VENDOR_LATCHED);

    // The first-alerter flag reports arbitration and never alerts itself,
    // which would otherwise hold the alert on forever.
    d.alert_request = |(d.cml & CML_SUPPORTED & ~alert_mask_cml)
                      || |(d.vendor & VENDOR_LATCHED & ~alert_mask_vendor);

    // Read answers, one cycle after the command
    d.rsp_valid = 1'b0;
    d.rsp_data  = 16'h0000;
    if (accepted && !cmd_write) begin
      case (cmd_code)
        CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS: begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = {8'h00, q.cml};
        end
        CMD_STATUS_OTHER: begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = {8'h00, q.other};
        end
        CMD_STATUS_VENDOR: begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = {8'h00, q.vendor};
        end
        CMD_INPUT_VOLTAGE_READING: begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = vin_link.reading;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q                <= '0;
      q.cml            <= CML_RESET;
      q.other          <= OTHER_RESET;
      q.vendor         <= VENDOR_RESET;
      q.rsp_data       <= VIN_RESET;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from the state register
  assign rsp_valid      = q.rsp_valid;
  assign rsp_data       = q.rsp_data;
  assign cml_summary    = q.cml_summary;
  assign other_summary  = q.other_summary;
  assign vendor_summary = q.vendor_summary;
  assign alert_request  = q.alert_request;

endmodule

`default_nettype wire

/* File: verilog/status_bank_pkg.sv */
`default_nettype none

package status_bank_pkg;

  // Command codes of this bank
  localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
  localparam logic [7:0] CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS     = 8'h7E;
  localparam logic [7:0] CMD_STATUS_OTHER   = 8'h7F;
  localparam logic [7:0] CMD_STATUS_VENDOR  = 8'h80;
  localparam logic [7:0] CMD_INPUT_VOLTAGE_READING       = 8'h88;

  // Communication, logic and memory status byte
  localparam int         CML_INVALID_CMD_BIT  = 7;
  localparam int         CML_INVALID_DATA_BIT = 6;
  localparam int         CML_PEC_BIT          = 5;
  localparam int         CML_MEMORY_BIT       = 4;
  localparam int         CML_LOGIC_CORE_BIT   = 3;
  localparam int         CML_COMMUNICATION_ERROR_FLAG_BIT         = 1;
  localparam logic [7:0] CML_SUPPORTED        = 8'hFA;
  localparam logic [7:0] CML_RESET            = 8'h00;

  // Miscellaneous status byte
  localparam int         OTHER_FIRST_ALERT_BIT = 0;
  localparam logic [7:0] OTHER_SUPPORTED       = 8'h01;
  localparam logic [7:0] OTHER_RESET           = 8'h00;

  // Vendor status byte
  localparam int         VENDOR_POWER_ON_BIT   = 7;
  localparam int         VENDOR_SELF_CHECK_BIT = 6;
  localparam int         VENDOR_RESTART_BIT    = 3;
  localparam int         VENDOR_BACK_CHAN_BIT  = 2;
  localparam int         VENDOR_SYNC_BIT       = 1;
  localparam logic [7:0] VENDOR_LATCHED        = 8'h8E;
  localparam logic [7:0] VENDOR_RESET          = 8'h00;

  // Input-voltage telemetry
  localparam logic [7:0]  PHASE_ALL       = 8'hFF;
  localparam int          VIN_EXP_LSB     = 11;
  localparam int          VIN_WORD_WIDTH  = 16;
  localparam logic [15:0] VIN_RESET       = 16'h0000;
  localparam int          PHASE_COUNT     = 4;

  // Refresh timing
  localparam int REFRESH_TIME_NS  = 1000000;
  localparam int CLOCK_PERIOD_PS  = 5000;
  localparam int REFRESH_CYCLES   = (REFRESH_TIME_NS / CLOCK_PERIOD_PS) * 1000;

  // Linear format: exponent over mantissa, both two's complement
  typedef struct packed {
    logic signed [4:0]  exponent;
    logic signed [10:0] mantissa;
  } linear_word_type;

endpackage

`default_nettype wire

/* File: verilog/vin_link_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface vin_link_if;
  logic [7:0]  phase_sel;
  logic [15:0] reading;

  modport source (
    input  phase_sel,
    output reading
  );

  modport sink (
    output phase_sel,
    input  reading
  );
endinterface

`default_nettype wire

/* File: verilog/vin_sampler.sv */
`timescale 1ns/10ps
`default_nettype none

module vin_sampler
  import status_bank_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES_P = REFRESH_CYCLES,
  parameter int unsigned PHASES           = PHASE_COUNT
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      srst,
  // Converter readings, already in linear format
  input  wire logic [15:0]               leader_vin_word,
  input  wire logic [PHASES*16-1:0]      phase_vin_word,
  // Readout toward the bank
  vin_link_if.source                     link
);

  localparam int CW = (REFRESH_CYCLES_P > 1) ? $clog2(REFRESH_CYCLES_P) : 1;
  localparam logic [CW-1:0] RELOAD = CW'(REFRESH_CYCLES_P - 1);

  typedef struct packed {
    logic [CW-1:0]                 tick_count;
    linear_word_type               leader;
    linear_word_type [PHASES-1:0]  phase;
    linear_word_type               reading;
  } sampler_state_type;

  sampler_state_type q, d;
  linear_word_type   selected;

  // Out-of-range phase numbers fall back to the leader reading
  always_comb begin
    selected = q.leader;
    if (link.phase_sel != PHASE_ALL && 32'(link.phase_sel) < PHASES) begin
      selected = q.phase[link.phase_sel];
    end
  end

  always_comb begin
    d = q;
    d.reading = selected;
    if (q.tick_count == '0) begin
      // Snapshot once per period so a read never sees a half-updated word
      d.tick_count = RELOAD;
      d.leader     = linear_word_type'(leader_vin_word);
      for (int i = 0; i < int'(PHASES); i++) begin
        d.phase[i] = linear_word_type'(phase_vin_word[i*16 +: 16]);
      end
    end else begin
      d.tick_count = q.tick_count - CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.reading = q.reading;

endmodule

`default_nettype wire

/* File: bench/status_bank_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module status_bank_properties
  import status_bank_pkg::*;
(
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       cmd_valid,
  input wire logic       cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic       cmd_pec_ok,
  input wire logic       rsp_valid,
  input wire logic       unsupported_cmd_event,
  input wire logic       invalid_data_event,
  input wire logic       memory_error_event,
  input wire logic       logic_core_error_event,
  input wire logic       communication_error_flag_error_event,
  input wire logic       is_follower,
  input wire logic       back_channel_fault,
  input wire logic [7:0] alert_mask_cml,
  input wire logic       cml_summary,
  input wire logic       alert_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic wr;
  logic ev;
  assign wr = cmd_valid && cmd_write && cmd_pec_ok;
  // Any source that could set a bit in the same cycle as a clear-all
  assign ev = unsupported_cmd_event || invalid_data_event || memory_error_event
              || logic_core_error_event || communication_error_flag_error_event || back_channel_fault;

  mem_summary_a: assert property (memory_error_event |=> cml_summary)
    else $error("memory error did not raise cml summary");
  communication_error_flag_summary_a: assert property (communication_error_flag_error_event |=> cml_summary)
    else $error("communication_error_flag error did not raise cml summary");
  follower_fault_a: assert property (is_follower && back_channel_fault |=> cml_summary)
    else $error("follower back-channel fault missing from cml");
  pec_fail_a: assert property (cmd_valid && !cmd_pec_ok |=> cml_summary && !rsp_valid)
    else $error("bad check byte not flagged or answered");
  ro_write_a: assert property (wr && cmd_code == CMD_INPUT_VOLTAGE_READING |=> cml_summary && !rsp_valid)
    else $error("write to voltage reading not flagged");
  clear_all_a: assert property (wr && cmd_code == CMD_CLEAR_FAULTS && !ev |=> !cml_summary)
    else $error("clear-all left cml summary set");
  summary_hold_a: assert property (cml_summary && !cmd_valid |=> cml_summary)
    else $error("cml summary dropped without a command");
  mask_alert_a: assert property (memory_error_event && !alert_mask_cml[4] |=> alert_request)
    else $error("unmasked memory error raised no alert");
endmodule
bind pmbus_status_telemetry_bank status_bank_properties chk (.clock, .srst, .cmd_valid,
  .cmd_write, .cmd_code, .cmd_pec_ok, .rsp_valid, .unsupported_cmd_event, .invalid_data_event,
  .memory_error_event, .logic_core_error_event, .communication_error_flag_error_event, .is_follower,
  .back_channel_fault, .alert_mask_cml, .cml_summary, .alert_request);
`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        clock,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [7:0]       cmd_wdata,
  output logic             cmd_pec_ok
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    cmd_pec_ok = 1'b1;
  end
  // A write of 1 bits asks the device to clear those flags
  task automatic send(input logic wr, input logic [7:0] code, data, input logic pec);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = data;
    cmd_pec_ok = pec;
    @(negedge clock);
    cmd_valid = 1'b0;
    // Idle fields are scrambled so nothing leans on stale values
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask
  task automatic read(input logic [7:0] code, input logic pec, output logic [15:0] val,
                      output logic got);
    send(1'b0, code, 8'h00, pec);
    got = 1'b0;
    val = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      if (rsp_valid === 1'b1 && !got) begin
        got = 1'b1;
        val = rsp_data;
      end
      @(negedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* File: bench/pmbus_status_telemetry_bank_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module pmbus_status_telemetry_bank_bench;
  import status_bank_pkg::*;
  logic        clock, srst, cmd_valid, cmd_write, cmd_pec_ok, rsp_valid;
  logic        is_follower, back_channel_fault, first_alert_won, alert_released;
  logic        power_on_check_fail, self_check_busy, output_restart_event, sync_fault_event;
  logic        cml_summary, other_summary, vendor_summary, alert_request;
  logic [4:0]  cml_ev;
  logic [7:0]  cmd_code, cmd_wdata, alert_mask_cml, alert_mask_vendor, phase_select;
  logic [15:0] rsp_data, leader_vin_word;
  logic [63:0] phase_vin_word;
  int          failures = 0;
  int          checks_done = 0;

  host_model host (.clock, .rsp_valid, .rsp_data, .cmd_valid, .cmd_write, .cmd_code,
                   .cmd_wdata, .cmd_pec_ok);
  pmbus_status_telemetry_bank #(.REFRESH_CYCLES_P(8), .PHASES(4)) dut (
    .clock, .srst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .cmd_pec_ok, .rsp_valid,
    .rsp_data, .unsupported_cmd_event(cml_ev[0]), .invalid_data_event(cml_ev[1]),
    .memory_error_event(cml_ev[2]), .logic_core_error_event(cml_ev[3]),
    .communication_error_flag_error_event(cml_ev[4]), .is_follower, .back_channel_fault, .first_alert_won,
    .alert_released, .power_on_check_fail, .self_check_busy, .output_restart_event,
    .sync_fault_event, .alert_mask_cml, .alert_mask_vendor, .phase_select,
    .leader_vin_word, .phase_vin_word, .cml_summary, .other_summary, .vendor_summary,
    .alert_request);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp, input string what);
    logic [15:0] v;
    logic        g;
    host.read(code, 1'b1, v, g);
    check({15'h0000, g}, 16'h0001, what);
    check(v, exp, what);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic t_cml;
    int b[5] = '{7, 6, 4, 3, 1};
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 5; i++) begin
        alert_mask_cml = (m == 1) ? 8'(32'h1 << b[i]) : 8'h00;
        @(negedge clock);
        cml_ev[i] = 1'b1;
        @(negedge clock);
        cml_ev[i] = 1'b0;
        @(negedge clock);
        check({14'h0, cml_summary, alert_request}, {14'h0, 1'b1, m == 0}, "flag");
        rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'(32'h1 << b[i]), "cml");
        host.send(1'b1, CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 8'h00, 1'b1);
        rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'(32'h1 << b[i]), "zero write");
        host.send(1'b1, CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 8'(32'h1 << b[i]), 1'b1);
        @(negedge clock);
        check({15'h0, cml_summary}, 16'h0000, "summary");
        rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0000, "cleared");
      end
    end
    alert_mask_cml = 8'h00;
    $display("cml flags done");
  endtask

  task automatic t_pec;
    logic [15:0] v;
    logic        g;
    host.read(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 1'b0, v, g);
    check({15'h0, g}, 16'h0000, "dropped");
    rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0020, "check byte");
    // Clear of bit 4 lands in the same cycle as a new memory error
    fork
      host.send(1'b1, CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 8'h30, 1'b1);
      begin
        @(negedge clock);
        cml_ev[2] = 1'b1;
        @(negedge clock);
        cml_ev[2] = 1'b0;
      end
    join
    rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0010, "set wins");
    host.send(1'b1, CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 8'h10, 1'b1);
    $display("check byte done");
  endtask

  task automatic t_vendor;
    is_follower = 1'b1;
    self_check_busy = 1'b1;
    alert_mask_cml = 8'h02;
    alert_mask_vendor = 8'h8E;
    @(negedge clock);
    {power_on_check_fail, output_restart_event, back_channel_fault, sync_fault_event} = 4'hF;
    @(negedge clock);
    {power_on_check_fail, output_restart_event, back_channel_fault, sync_fault_event} = 4'h0;
    check({15'h0, alert_request}, 16'h0000, "vendor masked");
    alert_mask_vendor = 8'h00;
    @(negedge clock);
    check({15'h0, alert_request}, 16'h0001, "vendor alert");
    alert_mask_cml = 8'h00;
    rd(CMD_STATUS_VENDOR, 16'h00CE, "vendor");
    rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0002, "follower");
    check({15'h0, vendor_summary}, 16'h0001, "vendor sum");
    // Live bit 6 must survive a write of one
    host.send(1'b1, CMD_STATUS_VENDOR, 8'h48, 1'b1);
    rd(CMD_STATUS_VENDOR, 16'h00C6, "vendor w1c");
    host.send(1'b1, CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    self_check_busy = 1'b0;
    rd(CMD_STATUS_VENDOR, 16'h0000, "vendor clr");
    rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0000, "cml clr");
    is_follower = 1'b0;
    $display("vendor done");
  endtask

  task automatic t_other;
    // Cleared by bus release, by a write of one, then by clear-all
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      first_alert_won = 1'b1;
      @(negedge clock);
      first_alert_won = 1'b0;
      rd(CMD_STATUS_OTHER, 16'h0001, "first");
      check({15'h0, other_summary}, 16'h0001, "other sum");
      if (k == 0) begin
        alert_released = 1'b1;
        @(negedge clock);
        alert_released = 1'b0;
      end else begin
        host.send(1'b1, (k == 1) ? CMD_STATUS_OTHER : CMD_CLEAR_FAULTS, 8'h01, 1'b1);
      end
      rd(CMD_STATUS_OTHER, 16'h0000, "released");
      check({15'h0, other_summary}, 16'h0000, "other sum clr");
    end
    $display("misc done");
  endtask

  task automatic t_vin;
    phase_vin_word = {16'hCA12, 16'hC9F0, 16'hCB00, 16'hC800};
    repeat (12) @(negedge clock);
    rd(CMD_INPUT_VOLTAGE_READING, 16'hD3C0, "leader");
    leader_vin_word = 16'hD3A7;
    repeat (12) @(negedge clock);
    rd(CMD_INPUT_VOLTAGE_READING, 16'hD3A7, "refresh");
    phase_select = 8'h02;
    repeat (12) @(negedge clock);
    rd(CMD_INPUT_VOLTAGE_READING, 16'hC9F0, "phase");
    host.send(1'b1, CMD_INPUT_VOLTAGE_READING, 8'h00, 1'b1);
    rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0080, "ro write");
    $display("voltage done");
  endtask

  initial begin
    srst = 1'b1;
    {cml_ev, is_follower, back_channel_fault, first_alert_won, alert_released} = '0;
    {power_on_check_fail, self_check_busy, output_restart_event, sync_fault_event} = '0;
    alert_mask_cml = 8'h00;
    alert_mask_vendor = 8'h00;
    phase_select = PHASE_ALL;
    leader_vin_word = 16'hD3C0;
    phase_vin_word = '0;
    repeat (12) @(negedge clock);
    srst = 1'b0;
    rd(CMD_COMMUNICATION_ERROR_FLAG_LOGIC_MEMORY_STATUS, 16'h0000, "reset cml");
    rd(CMD_STATUS_OTHER, 16'h0000, "reset misc");
    rd(CMD_STATUS_VENDOR, 16'h0000, "reset vendor");
    t_cml;
    t_pec;
    t_vendor;
    t_other;
    t_vin;
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop;
  end
endmodule
`default_nettype wire
